// file: rtl/irq_flag_bus_grant_pkg.sv
// constants for interrupt/flag recognition and bus request/grant logic
// assumes a single 50 MHz clock shared by core and this block
package irq_flag_bus_grant_pkg;
  localparam int          clock_period_ns     = 20;
  localparam int          min_pulse_ns        = 10;
  // shortest pulse that the input sampler still has to see, in cycles (at least one)
  localparam int          min_pulse_cycles    = (min_pulse_ns + clock_period_ns - 1)
                                                / clock_period_ns;
  localparam int          irq_count           = 3;
  localparam int          sync_stages         = 2;
  localparam logic        mode_level          = 1'b0;
  localparam logic        mode_edge           = 1'b1;
  localparam logic        reset_grant_n       = 1'b1;
  localparam logic        reset_select_n      = 1'b1;
  localparam logic        reset_line_n        = 1'b1;
  localparam logic        reset_pending       = 1'b0;
  localparam logic        reset_flag          = 1'b0;
  localparam logic        reset_stall         = 1'b0;
  localparam logic        reset_enable        = 1'b1;

  typedef enum logic [1:0] {
    bus_owned    = 2'b00,
    bus_releasing = 2'b01,
    bus_granted  = 2'b11,
    bus_reclaim  = 2'b10
  } bus_state_type;
endpackage

// file: rtl/input_sync.sv
// two-flip-flop synchroniser for one asynchronous input bit
// assumes the reset copy given is already released synchronously
`timescale 1ns/1ns
module input_sync
  import irq_flag_bus_grant_pkg::*;
#(
  parameter logic reset_value = 1'b1
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      sync_out
);
  logic first_stage;
  logic next_first_stage;
  logic next_sync_out;

  always_comb begin
    next_first_stage = async_in;
    next_sync_out    = first_stage;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      first_stage <= reset_value;
      sync_out    <= reset_value;
    end else begin
      first_stage <= next_first_stage;
      sync_out    <= next_sync_out;
    end
  end
endmodule

// file: rtl/irq_flag_bus_grant_sync.sv
// interrupt/flag input recognition and external bus request/grant handshake
// assumes core pulses service_done per line and gives its own select/strobe values
// pins leave as value and enable pairs; the pad ring builds the actual drivers
`timescale 1ns/1ns
module irq_flag_bus_grant_sync
  import irq_flag_bus_grant_pkg::*;
#(
  parameter int irq_lines = irq_count
) (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic [irq_lines-1:0] ext_interrupt_req_n,
  input  wire logic [irq_lines-1:0] irq_edge_mode,
  input  wire logic [irq_lines-1:0] service_done,
  input  wire logic                 flag_input,
  input  wire logic                 bus_request_n,
  input  wire logic                 core_data_mem_select_n,
  input  wire logic                 core_program_mem_select_n,
  input  wire logic                 core_boot_mem_select_n,
  input  wire logic                 core_read_n,
  input  wire logic                 core_write_n,
  output logic [irq_lines-1:0]      irq_pending,
  output logic                      flag_sampled,
  output logic                      bus_grant_n,
  output logic                      core_stall,
  output logic                      data_mem_select_n,
  output logic                      data_mem_select_oe,
  output logic                      program_mem_select_n,
  output logic                      program_mem_select_oe,
  output logic                      boot_mem_select_n,
  output logic                      boot_mem_select_oe,
  output logic                      read_n,
  output logic                      read_oe,
  output logic                      write_n,
  output logic                      write_oe
);
  logic                 reset_meta;
  logic                 reset_sync_b;
  logic                 next_reset_meta;
  logic                 next_reset_sync_b;
  logic [irq_lines-1:0] irq_sync_n;
  logic [irq_lines-1:0] irq_prev_n;
  logic [irq_lines-1:0] next_irq_prev_n;
  logic [irq_lines-1:0] next_irq_pending;
  logic                 flag_sync;
  logic                 next_flag_sampled;
  logic                 request_sync_n;
  bus_state_type        bus_state;
  bus_state_type        next_bus_state;
  logic                 next_bus_grant_n;
  logic                 next_core_stall;
  logic                 next_drive;
  logic                 drive;
  logic [4:0]           next_pins;

  // reset released through two flops so every flop leaves reset on one edge
  always_comb begin
    next_reset_meta   = 1'b1;
    next_reset_sync_b = reset_meta;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reset_meta   <= 1'b0;
      reset_sync_b <= 1'b0;
    end else begin
      reset_meta   <= next_reset_meta;
      reset_sync_b <= next_reset_sync_b;
    end
  end

  // each pin passes two flops before any logic, which sets the once-per-cycle sampling
  // limitation: a pulse shorter than one clock can slip between samples and be lost
  // lines idle high, so their synchronisers reset high and reset fakes no request
  genvar g;
  generate
    for (g = 0; g < irq_lines; g++) begin : irq_in
      input_sync #(.reset_value(reset_line_n)) u_sync (
        .clock    (clock),
        .rst_b    (reset_sync_b),
        .async_in (ext_interrupt_req_n[g]),
        .sync_out (irq_sync_n[g])
      );
    end
  endgenerate

  // flag idles low
  input_sync #(.reset_value(reset_flag)) u_flag_sync (
    .clock    (clock),
    .rst_b    (reset_sync_b),
    .async_in (flag_input),
    .sync_out (flag_sync)
  );

  // a low reset value here would read as a request on the first cycle
  input_sync #(.reset_value(reset_line_n)) u_request_sync (
    .clock    (clock),
    .rst_b    (reset_sync_b),
    .async_in (bus_request_n),
    .sync_out (request_sync_n)
  );

  // edge mode: falling edge latches, cleared by service; set wins over clear
  // level mode: pending simply follows the line, the source holds it
  // service_done is ignored in level mode; the source releasing the line clears it
  always_comb begin
    next_irq_prev_n   = irq_sync_n;
    next_flag_sampled = flag_sync;
    for (int i = 0; i < irq_lines; i++) begin
      if (irq_edge_mode[i] == mode_edge) begin
        if (irq_prev_n[i] && !irq_sync_n[i]) begin
          next_irq_pending[i] = 1'b1;
        end else if (service_done[i]) begin
          next_irq_pending[i] = 1'b0;
        end else begin
          next_irq_pending[i] = irq_pending[i];
        end
      end else begin
        next_irq_pending[i] = !irq_sync_n[i];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_sync_b) begin
    if (!reset_sync_b) begin
      // prev resets to the idle level so no false edge follows reset
      irq_prev_n   <= {irq_lines{reset_line_n}};
      irq_pending  <= {irq_lines{reset_pending}};
      flag_sampled <= reset_flag;
    end else begin
      irq_prev_n   <= next_irq_prev_n;
      irq_pending  <= next_irq_pending;
      flag_sampled <= next_flag_sampled;
    end
  end

  // request seen -> float pins (cycle 1) -> grant low (cycle 2), never same cycle
  // grant waits a full cycle after the float so no pin is still driven when it falls
  always_comb begin
    next_bus_state   = bus_state;
    next_bus_grant_n = bus_grant_n;
    next_drive       = drive;
    unique case (bus_state)
      bus_owned: begin
        if (!request_sync_n) begin
          next_bus_state = bus_releasing;
          next_drive     = 1'b0;
        end
      end
      bus_releasing: begin
        next_bus_state   = bus_granted;
        next_bus_grant_n = 1'b0;
      end
      // request changes while releasing or reclaiming wait for the next pass
      bus_granted: begin
        if (request_sync_n) begin
          next_bus_state   = bus_reclaim;
          next_bus_grant_n = 1'b1;
        end
      end
      bus_reclaim: begin
        // one full cycle with grant high and pins still floating
        next_bus_state = bus_owned;
        next_drive     = 1'b1;
      end
    endcase
    // core is held whenever it does not own the pins
    next_core_stall = !next_drive;
    if (next_drive) begin
      next_pins = {core_data_mem_select_n, core_program_mem_select_n, core_boot_mem_select_n,
                   core_read_n, core_write_n};
    end else begin
      // released pins read as idle high so a stray enable never strobes memory
      next_pins = {5{reset_select_n}};
    end
  end

  // value and enable leave the same flop stage, so they switch on one edge
  always_ff @(posedge clock or negedge reset_sync_b) begin
    if (!reset_sync_b) begin
      bus_state             <= bus_owned;
      bus_grant_n           <= reset_grant_n;
      core_stall            <= reset_stall;
      drive                 <= reset_enable;
      data_mem_select_oe    <= reset_enable;
      program_mem_select_oe <= reset_enable;
      boot_mem_select_oe    <= reset_enable;
      read_oe               <= reset_enable;
      write_oe              <= reset_enable;
      data_mem_select_n     <= reset_select_n;
      program_mem_select_n  <= reset_select_n;
      boot_mem_select_n     <= reset_select_n;
      read_n                <= reset_select_n;
      write_n               <= reset_select_n;
    end else begin
      bus_state             <= next_bus_state;
      bus_grant_n           <= next_bus_grant_n;
      core_stall            <= next_core_stall;
      drive                 <= next_drive;
      data_mem_select_oe    <= next_drive;
      program_mem_select_oe <= next_drive;
      boot_mem_select_oe    <= next_drive;
      read_oe               <= next_drive;
      write_oe              <= next_drive;
      data_mem_select_n     <= next_pins[4];
      program_mem_select_n  <= next_pins[3];
      boot_mem_select_n     <= next_pins[2];
      read_n                <= next_pins[1];
      write_n               <= next_pins[0];
    end
  end
endmodule

// file: verification/irq_flag_bus_grant_sync_props.sv
// checker: interrupt, flag and bus grant timing at the ports
// assumes inputs move just after a rising clock edge
`timescale 1ns/1ns
module irq_flag_bus_grant_sync_props #(
  parameter int irq_lines = 3
) (
  input wire logic                 clock,
  input wire logic                 rst_b,
  input wire logic [irq_lines-1:0] ext_interrupt_req_n,
  input wire logic [irq_lines-1:0] irq_pending,
  input wire logic                 flag_input,
  input wire logic                 flag_sampled,
  input wire logic                 bus_request_n,
  input wire logic                 bus_grant_n,
  input wire logic                 core_stall,
  input wire logic                 read_oe,
  input wire logic                 write_oe,
  input wire logic                 data_mem_select_oe,
  input wire logic                 program_mem_select_oe,
  input wire logic                 boot_mem_select_oe
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  property p_flag;
    $rose(flag_input) |-> ##3 flag_sampled;
  endproperty
  a_flag: assert property (p_flag) else $error("flag missed");
  property p_irq;
    $fell(ext_interrupt_req_n[0]) |-> ##3 irq_pending[0];
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missed");
  // stall low means the core still owns the bus
  property p_late;
    $fell(bus_request_n) && !core_stall |-> bus_grant_n [*4];
  endproperty
  a_late: assert property (p_late) else $error("grant too early");
  property p_grant;
    $fell(bus_request_n) && !core_stall ##0 !bus_request_n [*5] |-> !bus_grant_n;
  endproperty
  a_grant: assert property (p_grant) else $error("grant missing");
  property p_off;
    !bus_grant_n |-> !(read_oe | write_oe | data_mem_select_oe | program_mem_select_oe
                       | boot_mem_select_oe);
  endproperty
  a_off: assert property (p_off) else $error("pins driven in grant");
  property p_order;
    $fell(bus_grant_n) |-> $past(core_stall) && !$past(read_oe);
  endproperty
  a_order: assert property (p_order) else $error("grant before release");
  property p_back;
    $rose(read_oe) |-> bus_grant_n && $past(bus_grant_n);
  endproperty
  a_back: assert property (p_back) else $error("pins back before grant off");
endmodule
bind irq_flag_bus_grant_sync irq_flag_bus_grant_sync_props #(.irq_lines(irq_lines)) props (
  .clock, .rst_b, .ext_interrupt_req_n, .irq_pending, .flag_input, .flag_sampled,
  .bus_request_n, .bus_grant_n, .core_stall, .read_oe, .write_oe, .data_mem_select_oe,
  .program_mem_select_oe, .boot_mem_select_oe
);

// file: verification/far_side_model.sv
// far side: interrupt sources and an external bus master
// assumes tasks are called at a rising clock edge
`timescale 1ns/1ns
module far_side_model (
  input  wire logic       clock,
  output logic      [2:0] irq_n,
  output logic            req_n
);
  initial irq_n = 3'h7;
  initial req_n = 1'b1;
  // whole cycles only, so each pulse is wider than 10 ns
  task automatic irq_low(input int line, input int n);
    irq_n[line] <= 1'b0;
    repeat (n) @(posedge clock);
    irq_n[line] <= 1'b1;
  endtask
  task automatic request(input int n);
    req_n <= 1'b0;
    repeat (n) @(posedge clock);
    req_n <= 1'b1;
  endtask
endmodule

// file: verification/irq_flag_bus_grant_sync_tb_top.sv
// bench: flag, interrupt and bus request scenarios
// assumes the far side model drives interrupt and request lines
`timescale 1ns/1ns
module irq_flag_bus_grant_sync_tb_top;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic [2:0] irq_edge_mode = 3'h1;
  logic [2:0] service_done = 3'h0;
  logic       flag_input = 1'b0;
  logic [4:0] core = 5'h0a;
  logic [2:0] ext_interrupt_req_n, irq_pending;
  logic       bus_request_n, flag_sampled, bus_grant_n, core_stall;
  logic [4:0] pins, oe;
  int         errors = 0;
  int         n_compared = 0;
  int         cycles = 0;
  always #10 clock = ~clock;
  far_side_model far (.clock, .irq_n(ext_interrupt_req_n), .req_n(bus_request_n));
  irq_flag_bus_grant_sync DUT (
    .*,
    .core_data_mem_select_n(core[4]), .core_program_mem_select_n(core[3]),
    .core_boot_mem_select_n(core[2]), .core_read_n(core[1]), .core_write_n(core[0]),
    .data_mem_select_n(pins[4]), .data_mem_select_oe(oe[4]),
    .program_mem_select_n(pins[3]), .program_mem_select_oe(oe[3]),
    .boot_mem_select_n(pins[2]), .boot_mem_select_oe(oe[2]),
    .read_n(pins[1]), .read_oe(oe[1]), .write_n(pins[0]), .write_oe(oe[0])
  );
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic t_flag();
    @(posedge clock) flag_input <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk("flag early", 5'h0, 5'(flag_sampled));
    @(posedge clock) #1 chk("flag", 5'h1, 5'(flag_sampled));
    @(posedge clock) flag_input <= 1'b0;
  endtask
  task automatic t_edge();
    far.irq_low(0, 1);
    repeat (8) @(posedge clock);
    #1 chk("edge held", 5'h1, 5'(irq_pending));
    @(posedge clock) service_done <= 3'h1;
    @(posedge clock) service_done <= 3'h0;
    #1 chk("edge cleared", 5'h0, 5'(irq_pending));
  endtask
  task automatic t_level();
    @(posedge clock);
    fork
      far.irq_low(1, 6);
      begin
        repeat (4) @(posedge clock);
        #1 chk("level", 5'h2, 5'(irq_pending));
      end
    join
    repeat (3) @(posedge clock);
    #1 chk("level gone", 5'h0, 5'(irq_pending));
  endtask
  task automatic t_bus();
    @(posedge clock);
    fork
      far.request(10);
      begin
        repeat (3) @(posedge clock);
        #1 chk("oe off", 5'h0, oe);
        chk("stall on", 5'h1, 5'(core_stall));
        chk("grant wait", 5'h1, 5'(bus_grant_n));
        @(posedge clock) #1 chk("grant", 5'h0, 5'(bus_grant_n));
        chk("pins idle", 5'h1f, pins);
      end
    join
    repeat (3) @(posedge clock);
    #1 chk("grant off", 5'h1, 5'(bus_grant_n));
    chk("oe still off", 5'h0, oe);
    @(posedge clock) #1 chk("oe back", 5'h1f, oe);
    chk("stall off", 5'h0, 5'(core_stall));
    chk("pins back", core, pins);
    @(posedge clock) far.request(1);
    repeat (8) @(posedge clock);
    #1 chk("short done", 5'h1f, oe);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_flag();
    t_edge();
    t_level();
    t_bus();
    summarize();
  end
endmodule
